// file: inc/adb_pkg.sv
/*
  Constants for the converter transfer flag block: register selects,
  field positions, reset values and widths.
  Assumes it is compiled before every design file that imports it.
*/
package adb_pkg;
  localparam int ADB_DATA_W = 16;
  localparam int ADB_CONV_N = 2;
  // Register selects on the special-function register port.
  localparam logic adb_sel_control = 1'h0;
  localparam logic adb_sel_config = 1'h1;
  // Control register fields.
  localparam int ADB_CN_MODE = 5;
  localparam int ADB_CN_ERR1 = 4;
  localparam int ADB_CN_ERR0 = 3;
  localparam int ADB_CN_WEN = 2;
  localparam int ADB_CN_WARN1 = 1;
  localparam int ADB_CN_WARN0 = 0;
  // Configuration register fields.
  localparam int ADB_CF_HALT = 7;
  localparam int ADB_CF_BUSY = 6;
  localparam int ADB_CF_CIE = 3;
  localparam int ADB_CF_EOE = 1;
  localparam logic [7:0] ADB_CN_RESET = 8'h00;
  localparam logic [7:0] ADB_CF_RESET = 8'h00;
  localparam int ADB_FIFO_DEPTH = 2;
endpackage

// file: hw/adb_buffer2.sv
/*
  Small first-in first-out buffer with valid and ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module adb_buffer2 #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 2
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH != 2 || WIDTH < 1) begin
      $error("adb_buffer2 serves a depth of two only");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [PW:0] count, next_count;
  logic push, pop;

  // Full and empty come straight from the count so they never lie.
  assign in_ready = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and count arithmetic.
  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count + (PW+1)'(push) - (PW+1)'(pop);
  end

  // Storage and pointers.
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

// file: hw/adb_dma_flags.sv
/*
  Transfer engine flag and buffer logic for two converters: holding
  buffers, overflow warnings and errors, mode select, halt handshake.
  Assumes converter done pulses come from logic on the same clock and
  that the data memory accepts words by valid and ready.
*/
`timescale 1ns/1ps
module adb_dma_flags
  import adb_pkg::*;
#(
  parameter int DATA_W = adb_pkg::ADB_DATA_W
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Special-function register port.
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic sfr_sel,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Converter results.
  input wire logic [adb_pkg::ADB_CONV_N-1:0] conv_done,
  input wire logic [DATA_W-1:0] conv0_data,
  input wire logic [DATA_W-1:0] conv1_data,
  // Data memory write stream.
  input wire logic mem_offchip,
  output logic mem_valid,
  input wire logic mem_ready,
  output logic [DATA_W-1:0] mem_data,
  output logic mem_chan,
  // Status toward the processor.
  output logic transfer_mode_select,
  output logic warning_irq,
  output logic error_irq
);
  import adb_pkg::*;

  initial begin
    if (DATA_W < 1) begin
      $error("adb_dma_flags needs a data width of at least one");
    end
  end

  logic [DATA_W-1:0] conv_data [ADB_CONV_N];
  assign conv_data[0] = conv0_data;
  assign conv_data[1] = conv1_data;

  // Register state.
  logic mode, next_mode;
  logic warn_en, next_warn_en;
  logic [ADB_CONV_N-1:0] err_flag, next_err_flag;
  logic [ADB_CONV_N-1:0] warn_flag, next_warn_flag;
  logic halt, next_halt;
  logic cie, next_cie, eoe, next_eoe;
  logic [7:0] next_sfr_rdata;

  // Holding buffer and converter data register per converter.
  logic [DATA_W-1:0] hold [ADB_CONV_N];
  logic [DATA_W-1:0] next_hold [ADB_CONV_N];
  logic [DATA_W-1:0] pend [ADB_CONV_N];
  logic [DATA_W-1:0] next_pend [ADB_CONV_N];
  logic [ADB_CONV_N-1:0] hold_v, next_hold_v, pend_v, next_pend_v;
  logic last_chan, next_last_chan;

  // Buffer toward memory and its output stage.
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [DATA_W:0] fifo_in_data, fifo_out_data;
  logic next_mem_valid, next_mem_chan;
  logic [DATA_W-1:0] next_mem_data;
  logic next_warning_irq, next_error_irq;
  logic pick, pick_ok;
  logic [ADB_CONV_N-1:0] drain;
  logic halted;

  adb_buffer2 #(
    .WIDTH(DATA_W + 1),
    .DEPTH(ADB_FIFO_DEPTH)
  ) u_buf (
    .clk(clk),
    .rst(rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // Choose which holding buffer goes to memory next.
  always_comb begin
    pick = 1'b0;
    pick_ok = |hold_v;
    if (mode) begin
      // Second mode alternates converters so neither starves.
      pick = (hold_v[1] && (!hold_v[0] || !last_chan)) ? 1'b1 : 1'b0;
    end else begin
      // Default mode always favours the first converter.
      pick = hold_v[0] ? 1'b0 : 1'b1;
    end
    fifo_in_valid = pick_ok;
    fifo_in_data = {pick, hold[pick]};
    drain = '0;
    drain[pick] = pick_ok && fifo_in_ready;
    next_last_chan = (pick_ok && fifo_in_ready) ? pick : last_chan;
  end

  // Holding buffers, data registers and the hardware side of the flags.
  always_comb begin
    next_hold = hold;
    next_pend = pend;
    next_hold_v = hold_v;
    next_pend_v = pend_v;
    next_err_flag = err_flag;
    next_warn_flag = warn_flag;
    next_mode = mode;
    next_warn_en = warn_en;
    next_halt = halt;
    next_cie = cie;
    next_eoe = eoe;
    // Software writes can only clear flags; set below wins over clear.
    if (sfr_wr && sfr_sel == adb_sel_control) begin
      next_mode = sfr_wdata[ADB_CN_MODE];
      next_warn_en = sfr_wdata[ADB_CN_WEN];
      next_err_flag = err_flag & {sfr_wdata[ADB_CN_ERR1], sfr_wdata[ADB_CN_ERR0]};
      next_warn_flag = warn_flag & {sfr_wdata[ADB_CN_WARN1], sfr_wdata[ADB_CN_WARN0]};
    end
    if (sfr_wr && sfr_sel == adb_sel_config) begin
      next_halt = sfr_wdata[ADB_CF_HALT];
      next_cie = sfr_wdata[ADB_CF_CIE];
      next_eoe = sfr_wdata[ADB_CF_EOE];
    end
    for (int i = 0; i < ADB_CONV_N; i++) begin
      // A drained buffer is refilled from the waiting data register.
      if (drain[i]) begin
        next_hold_v[i] = pend_v[i];
        next_hold[i] = pend[i];
        next_pend_v[i] = 1'b0;
      end
      if (conv_done[i]) begin
        if (hold_v[i]) begin
          next_warn_flag[i] = 1'b1;
        end
        if (!next_hold_v[i]) begin
          next_hold_v[i] = 1'b1;
          next_hold[i] = conv_data[i];
        end else begin
          // Second result with no memory access waits in pend; a third overwrites the older pending word.
          if (next_pend_v[i]) begin
            next_err_flag[i] = 1'b1;
          end
          next_pend_v[i] = 1'b1;
          next_pend[i] = conv_data[i];
        end
      end
    end
  end

  // Output stage toward memory; halt blocks new off-chip words.
  always_comb begin
    halted = halt && mem_offchip;
    fifo_out_ready = (!mem_valid || mem_ready) && !halted;
    next_mem_valid = mem_valid;
    next_mem_data = mem_data;
    next_mem_chan = mem_chan;
    if (mem_valid && mem_ready) begin
      next_mem_valid = 1'b0;
    end
    if (fifo_out_valid && fifo_out_ready) begin
      next_mem_valid = 1'b1;
      next_mem_data = fifo_out_data[DATA_W-1:0];
      next_mem_chan = fifo_out_data[DATA_W];
    end
  end

  // Read data and interrupt levels.
  always_comb begin
    next_sfr_rdata = sfr_rdata;
    if (sfr_rd) begin
      next_sfr_rdata = 8'h00;
      if (sfr_sel == adb_sel_control) begin
        next_sfr_rdata[ADB_CN_MODE] = mode;
        next_sfr_rdata[ADB_CN_ERR1] = err_flag[1];
        next_sfr_rdata[ADB_CN_ERR0] = err_flag[0];
        next_sfr_rdata[ADB_CN_WEN] = warn_en;
        next_sfr_rdata[ADB_CN_WARN1] = warn_flag[1];
        next_sfr_rdata[ADB_CN_WARN0] = warn_flag[0];
      end else begin
        next_sfr_rdata[ADB_CF_HALT] = halt;
        next_sfr_rdata[ADB_CF_BUSY] = mem_valid && mem_offchip;
        next_sfr_rdata[ADB_CF_CIE] = cie;
        next_sfr_rdata[ADB_CF_EOE] = eoe;
      end
    end
    next_warning_irq = warn_en && (|warn_flag);
    next_error_irq = |err_flag;
  end

  // All state registers.
  always_ff @(posedge clk) begin
    if (rst) begin
      mode <= ADB_CN_RESET[ADB_CN_MODE];
      warn_en <= ADB_CN_RESET[ADB_CN_WEN];
      err_flag <= '0;
      warn_flag <= '0;
      halt <= ADB_CF_RESET[ADB_CF_HALT];
      cie <= ADB_CF_RESET[ADB_CF_CIE];
      eoe <= ADB_CF_RESET[ADB_CF_EOE];
      hold_v <= '0;
      pend_v <= '0;
      last_chan <= 1'b1;
      mem_valid <= 1'b0;
      mem_chan <= 1'b0;
      mem_data <= '0;
      sfr_rdata <= 8'h00;
      warning_irq <= 1'b0;
      error_irq <= 1'b0;
      transfer_mode_select <= 1'b0;
    end else begin
      mode <= next_mode;
      warn_en <= next_warn_en;
      err_flag <= next_err_flag;
      warn_flag <= next_warn_flag;
      halt <= next_halt;
      cie <= next_cie;
      eoe <= next_eoe;
      hold_v <= next_hold_v;
      pend_v <= next_pend_v;
      last_chan <= next_last_chan;
      mem_valid <= next_mem_valid;
      mem_chan <= next_mem_chan;
      mem_data <= next_mem_data;
      sfr_rdata <= next_sfr_rdata;
      warning_irq <= next_warning_irq;
      error_irq <= next_error_irq;
      transfer_mode_select <= next_mode;
    end
    hold <= next_hold;
    pend <= next_pend;
  end
endmodule

// file: tb/adb_dma_flags_chk.sv
/*
  Port checker for the converter transfer flag block.
  Assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/1ps
module adb_dma_flags_chk
  import adb_pkg::*;
#(
  parameter int DATA_W = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register port.
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic sfr_sel,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // Converter and memory side.
  input wire logic [adb_pkg::ADB_CONV_N-1:0] conv_done,
  input wire logic mem_offchip,
  input wire logic mem_valid,
  input wire logic mem_ready,
  input wire logic [DATA_W-1:0] mem_data,
  input wire logic mem_chan,
  // Status.
  input wire logic transfer_mode_select,
  input wire logic warning_irq,
  input wire logic error_irq
);
  logic cw;
  logic halt_q;
  logic next_halt;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // The halt bit is invisible at the ports, so it is mirrored here.
  assign cw = sfr_wr && !sfr_sel;
  always_comb begin
    next_halt = (sfr_wr && sfr_sel) ? sfr_wdata[ADB_CF_HALT] : halt_q;
  end
  always_ff @(posedge clk) begin
    halt_q <= rst ? 1'b0 : next_halt;
  end
  chk_mode_copy: assert property (cw |=> transfer_mode_select == $past(sfr_wdata[ADB_CN_MODE]))
    else $error("mode output differs from written bit");
  chk_err_hold: assert property (error_irq && !cw && !$past(cw) |=> error_irq)
    else $error("error flag dropped without a write");
  chk_warn_hold: assert property (warning_irq && !cw && !$past(cw) |=> warning_irq)
    else $error("warning dropped without a write");
  chk_warn_gate: assert property (cw && !sfr_wdata[ADB_CN_WEN] |=> ##1 !warning_irq)
    else $error("warning raised while disabled");
  chk_err_cause: assert property ($rose(error_irq) |-> $past(|conv_done, 2))
    else $error("error raised without a conversion");
  chk_halt_gate: assert property ($past(halt_q) && halt_q && mem_offchip && $past(mem_offchip) && !mem_valid
    |=> !mem_valid)
    else $error("word offered while halted");
  chk_mem_stable: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_data) && $stable(mem_chan))
    else $error("offered word changed before acceptance");
  chk_busy_bit: assert property (sfr_rd && sfr_sel |=> sfr_rdata[ADB_CF_BUSY] == $past(mem_valid && mem_offchip))
    else $error("busy bit wrong");
  cover property ($rose(error_irq));
  cover property ($rose(warning_irq));
  cover property (mem_valid && mem_ready && mem_chan);
endmodule

// file: tb/adb_mem_model.sv
/*
  Data memory sink model that accepts words on random cycles.
  Assumes the bench holds stall high to block it completely.
*/
`timescale 1ns/1ps
module adb_mem_model (
  // Clock.
  input wire logic clk,
  // Stall request from the bench.
  input wire logic stall,
  // Acceptance toward the engine.
  output logic mem_ready
);
  int seed = 88;
  initial mem_ready = 1'b0;
  // Random acceptance makes offered words wait, as a busy memory would.
  always @(posedge clk) begin
    mem_ready <= #1 !stall && (($random(seed) & 1) != 0);
  end
endmodule

// file: tb/adb_dma_flags_tb.sv
/*
  Self-checking bench for the converter transfer flag block.
  Assumes the package is compiled first and the memory model beside it.
*/
`timescale 1ns/1ps
module adb_dma_flags_tb;
  import adb_pkg::*;
  logic clk = 0, rst = 1, sfr_wr = 0, sfr_rd = 0, sfr_sel = 0, mem_offchip = 0, stall = 0, skip = 0, rd_d = 0;
  logic [7:0] sfr_wdata = 8'h00, sfr_rdata;
  logic [1:0] conv_done = 2'h0;
  logic [15:0] conv0_data = 16'h0000, conv1_data = 16'h0000, mem_data;
  logic mem_valid, mem_ready, mem_chan, transfer_mode_select, warning_irq, error_irq;
  logic [7:0] exp_rd[$];
  logic [16:0] exp_mem[$];
  int n_mismatch = 0, check_count = 0, seed = 88;
  always #50 clk = ~clk;
  adb_dma_flags adb_dma_flags_i (.clk(clk), .rst(rst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_sel(sfr_sel),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .conv_done(conv_done), .conv0_data(conv0_data),
    .conv1_data(conv1_data), .mem_offchip(mem_offchip), .mem_valid(mem_valid), .mem_ready(mem_ready),
    .mem_data(mem_data), .mem_chan(mem_chan), .transfer_mode_select(transfer_mode_select),
    .warning_irq(warning_irq), .error_irq(error_irq));
  adb_mem_model adb_mem_model_i (.clk(clk), .stall(stall), .mem_ready(mem_ready));
  task automatic tally(input bit bad, input string what);
    check_count++;
    if (bad) begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask
  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    tally(got !== exp, $sformatf("register %h expected %h", got, exp));
  endtask
  task automatic cmp_word(input logic [16:0] got, input logic [16:0] exp);
    tally(got !== exp, $sformatf("memory word %h expected %h", got, exp));
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic sel, input logic [7:0] d);
    sfr_sel = sel;
    sfr_wdata = d;
    sfr_wr = 1;
    tick();
    sfr_wr = 0;
    // An idle edge keeps a following strobe from rising in the same step.
    tick();
  endtask
  task automatic rd(input logic sel, input logic [7:0] exp);
    sfr_sel = sel;
    exp_rd.push_back(exp);
    sfr_rd = 1;
    tick();
    sfr_rd = 0;
    tick();
  endtask
  // Each new result is noted before it is handed over, converter 0 first, except while skip is set.
  task automatic conv(input logic [1:0] d);
    conv0_data = 16'($random(seed));
    conv1_data = 16'($random(seed));
    if (!skip && d[0]) exp_mem.push_back({1'b0, conv0_data});
    if (!skip && d[1]) exp_mem.push_back({1'b1, conv1_data});
    conv_done = d;
    tick();
    conv_done = 2'h0;
  endtask
  // Read data lands one cycle after the read edge; words are taken on acceptance.
  always @(posedge clk) begin
    if (rd_d) cmp_reg(sfr_rdata, exp_rd.pop_front());
    rd_d <= sfr_rd;
    if (mem_valid && mem_ready && !skip) cmp_word({mem_chan, mem_data}, exp_mem.pop_front());
  end
  // Cuts a hang short at 6000 cycles, well beyond the few hundred cycles the run needs.
  initial begin
    #(100 * 6000);
    n_mismatch++;
    conclude();
  end
  initial begin
    repeat (20) @(posedge clk);
    #1 rst = 0;
    rd(0, ADB_CN_RESET);
    rd(1, ADB_CF_RESET);
    wr(0, 8'h3f);
    rd(0, 8'h24);
    wr(1, 8'hff);
    rd(1, 8'h8a);
    wr(1, 8'h00);
    // Random traffic in both modes against a memory that stalls at random.
    for (int m = 0; m < 2; m++) begin
      wr(0, m ? 8'h24 : 8'h04);
      repeat (12) begin
        conv(2'(1 << ($random(seed) & 1)));
        repeat (8) tick();
      end
    end
    // Both converters overrun a stalled memory, so loss is expected here.
    repeat (20) tick();
    skip = 1;
    stall = 1;
    repeat (8) begin
      conv(2'h3);
      tick();
    end
    rd(0, 8'h3f);
    cmp_reg({6'h0, warning_irq, error_irq}, 8'h03);
    wr(0, 8'h3b);
    repeat (2) tick();
    cmp_reg({6'h0, warning_irq, error_irq}, 8'h01);
    stall = 0;
    repeat (60) tick();
    rd(0, 8'h3b);
    wr(0, 8'h00);
    skip = 0;
    repeat (2) tick();
    cmp_reg({6'h0, warning_irq, error_irq}, 8'h00);
    // A halted off-chip target must not receive the word until released.
    wr(1, 8'h80);
    mem_offchip = 1;
    conv(2'h1);
    repeat (20) tick();
    cmp_reg({7'h0, mem_valid}, 8'h00);
    rd(1, 8'h80);
    stall = 1;
    wr(1, 8'h00);
    repeat (6) tick();
    rd(1, 8'h40);
    stall = 0;
    repeat (20) tick();
    cmp_reg(8'(exp_mem.size()), 8'h00);
    conclude();
  end
endmodule
bind adb_dma_flags adb_dma_flags_chk #(.DATA_W(DATA_W)) adb_dma_flags_chk_i (.clk(clk), .rst(rst),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_sel(sfr_sel), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .conv_done(conv_done), .mem_offchip(mem_offchip), .mem_valid(mem_valid), .mem_ready(mem_ready),
  .mem_data(mem_data), .mem_chan(mem_chan), .transfer_mode_select(transfer_mode_select),
  .warning_irq(warning_irq), .error_irq(error_irq));
